// [src/mbs_pkg.sv]
// constants and types for the memory self-test address/pause control block
package mbs_pkg;
  // register selectors on the coprocessor access port
  localparam logic [1:0] MBS_REG_CTRL = 2'h0;
  localparam logic [1:0] MBS_REG_ADDR = 2'h1;
  localparam logic [1:0] MBS_REG_GEN  = 2'h2;
  // control register fields
  localparam int MBS_CTL_EN    = 0;
  localparam int MBS_CTL_START = 1;
  localparam int MBS_CTL_PAUSE = 2;
  localparam int MBS_CTL_SIZE  = 8;
  localparam int MBS_SIZE_W    = 8;
  // status bits in control readback
  localparam int MBS_ST_RUN  = 4;
  localparam int MBS_ST_DONE = 5;
  localparam int MBS_ST_FAIL = 6;
  localparam int MBS_ST_PSD  = 7;
  // reset values
  localparam logic [31:0] MBS_RST_ZERO = 32'h0000_0000;
  // sequencer states
  typedef enum logic [2:0] {
    MBS_IDLE, MBS_P1_WR, MBS_PAUSED, MBS_P2_CHK, MBS_P2_WR,
    MBS_P3_CHK, MBS_P3_WR, MBS_P3_CHK2
  } mbs_state_e;
endpackage

// [src/mbs_selftest.sv]
// self-test sequencer with address/general registers, one per side
`timescale 1ns/1ps
module mbs_selftest
  import mbs_pkg::*;
#(
  parameter int AW = 12
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // coprocessor register access
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic              reg_side,
  input  wire logic [1:0]        reg_sel,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  // instruction-side array port
  output logic                   i_mem_en,
  output logic                   i_mem_we,
  output logic      [AW-1:0]     i_mem_addr,
  output logic      [31:0]       i_mem_wdata,
  input  wire logic [31:0]       i_mem_rdata,
  // data-side array port
  output logic                   d_mem_en,
  output logic                   d_mem_we,
  output logic      [AW-1:0]     d_mem_addr,
  output logic      [31:0]       d_mem_wdata,
  input  wire logic [31:0]       d_mem_rdata,
  // functional enables of the arrays
  output logic                   i_func_en,
  output logic                   d_func_en
);
  // per-side state, index 0 instruction, 1 data
  mbs_state_e        st       [2];
  logic              en       [2];
  logic              pause    [2];
  logic [MBS_SIZE_W-1:0] size [2];
  logic              run      [2];
  logic              done     [2];
  logic              fail     [2];
  logic [AW-1:0]     start_a  [2];
  logic [31:0]       seed     [2];
  logic [AW-1:0]     pp_addr  [2];
  logic [AW-1:0]     cur      [2];
  logic [AW-1:0]     top      [2];
  logic [AW-1:0]     fail_a   [2];
  logic [31:0]       fail_d   [2];
  logic              pp_rd    [2];
  logic [31:0]       pk_d     [2];
  logic [31:0]       mrd      [2];
  logic              m_en     [2];
  logic              m_we     [2];
  logic [AW-1:0]     m_addr   [2];
  logic [31:0]       m_wd     [2];

  assign mrd[0] = i_mem_rdata;
  assign mrd[1] = d_mem_rdata;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_side
      logic wsel;
      logic ctl_wr;
      logic mism;
      logic peek;
      logic [31:0] expect_v;
      assign wsel   = reg_wr && (reg_side == 1'(g));
      assign ctl_wr = wsel && reg_sel == MBS_REG_CTRL;
      // expected value for the check states
      always_comb
      begin
        unique case (st[g])
          MBS_P2_CHK, MBS_P3_CHK2: expect_v = seed[g];
          default:                 expect_v = ~seed[g];
        endcase
      end
      assign mism = (st[g] == MBS_P2_CHK || st[g] == MBS_P3_CHK ||
                     st[g] == MBS_P3_CHK2) && mrd[g] != expect_v;

      // control register fields
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          en[g]    <= 1'b0;
          pause[g] <= 1'b0;
          size[g]  <= '0;
        end
        else if (ctl_wr)
        begin
          en[g]    <= reg_wdata[MBS_CTL_EN];
          pause[g] <= reg_wdata[MBS_CTL_PAUSE];
          size[g]  <= reg_wdata[MBS_CTL_SIZE +: MBS_SIZE_W];
        end
      end

      // start address, seed and peek/poke address
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          start_a[g] <= '0;
          seed[g]    <= MBS_RST_ZERO;
          pp_addr[g] <= '0;
        end
        else if (wsel && !pause[g] && reg_sel == MBS_REG_ADDR)
          start_a[g] <= reg_wdata[AW-1:0];
        else if (wsel && !pause[g] && reg_sel == MBS_REG_GEN)
          seed[g] <= reg_wdata;
        else if (wsel && pause[g] && reg_sel == MBS_REG_ADDR)
          pp_addr[g] <= reg_wdata[AW-1:0];
      end

      // sequencer through the three passes
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          st[g]     <= MBS_IDLE;
          cur[g]    <= '0;
          top[g]    <= '0;
          run[g]    <= 1'b0;
          done[g]   <= 1'b0;
          fail[g]   <= 1'b0;
        end
        else
        begin
          unique case (st[g])
            MBS_IDLE:
              if (ctl_wr && reg_wdata[MBS_CTL_START] && en[g])
              begin
                st[g]   <= MBS_P1_WR;
                cur[g]  <= start_a[g];
                top[g]  <= start_a[g] + AW'(reg_wdata[MBS_CTL_SIZE +:
                           MBS_SIZE_W]);
                run[g]  <= 1'b1;
                done[g] <= 1'b0;
                fail[g] <= 1'b0;
              end
            MBS_P1_WR:
              if (cur[g] == top[g])
              begin
                cur[g] <= start_a[g];
                if (pause[g])
                begin
                  st[g]  <= MBS_PAUSED;
                  run[g] <= 1'b0;
                end
                else
                  st[g] <= MBS_P2_CHK;
              end
              else
                cur[g] <= cur[g] + AW'(1);
            MBS_PAUSED:
              if (ctl_wr && reg_wdata[MBS_CTL_START])
              begin
                st[g]  <= MBS_P2_CHK;
                run[g] <= 1'b1;
              end
            MBS_P2_CHK, MBS_P3_CHK, MBS_P3_CHK2:
              if (mism)
              begin
                st[g]     <= MBS_IDLE;
                run[g]    <= 1'b0;
                done[g]   <= 1'b1;
                fail[g]   <= 1'b1;
              end
              else if (st[g] == MBS_P2_CHK)
                st[g] <= MBS_P2_WR;
              else if (st[g] == MBS_P3_CHK)
                st[g] <= MBS_P3_WR;
              else if (cur[g] == start_a[g])
              begin
                st[g]   <= MBS_IDLE;
                run[g]  <= 1'b0;
                done[g] <= 1'b1;
              end
              else
              begin
                st[g]  <= MBS_P3_CHK;
                cur[g] <= cur[g] - AW'(1);
              end
            MBS_P2_WR:
              if (cur[g] == top[g])
                st[g] <= MBS_P3_CHK;
              else
              begin
                st[g]  <= MBS_P2_CHK;
                cur[g] <= cur[g] + AW'(1);
              end
            MBS_P3_WR:
              st[g] <= MBS_P3_CHK2;
            default:
              st[g] <= MBS_IDLE;
          endcase
        end
      end

      // failing location and data, held until a later failure
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          fail_a[g] <= '0;
          fail_d[g] <= MBS_RST_ZERO;
        end
        else if (mism)
        begin
          fail_a[g] <= cur[g];
          fail_d[g] <= mrd[g];
        end
      end

      // array port: sequencer first, then peek/poke while paused
      always_comb
      begin
        m_en[g]   = 1'b0;
        m_we[g]   = 1'b0;
        m_addr[g] = cur[g];
        m_wd[g]   = seed[g];
        unique case (st[g])
          MBS_P1_WR, MBS_P3_WR:
          begin
            m_en[g] = 1'b1;
            m_we[g] = 1'b1;
          end
          MBS_P2_WR:
          begin
            m_en[g] = 1'b1;
            m_we[g] = 1'b1;
            m_wd[g] = ~seed[g];
          end
          MBS_P2_CHK, MBS_P3_CHK, MBS_P3_CHK2:
            m_en[g] = 1'b1;
          default:
            if (pause[g] && reg_sel == MBS_REG_GEN &&
                (wsel || (reg_rd && reg_side == 1'(g))))
            begin
              m_en[g]   = 1'b1;
              m_we[g]   = wsel;
              m_addr[g] = pp_addr[g];
              m_wd[g]   = reg_wdata;
            end
        endcase
      end

      // a peek is an array read outside the sequencer's own states
      assign peek = m_en[g] && !m_we[g] && pause[g] &&
                    (st[g] == MBS_IDLE || st[g] == MBS_PAUSED);

      // marks that the next read result is peek data
      always_ff @(posedge clk)
      begin
        if (srst)
          pp_rd[g] <= 1'b0;
        else
          pp_rd[g] <= peek;
      end

      // peek data is taken while the array still drives it; the array
      // port is released as soon as the read strobe drops
      always_ff @(posedge clk)
      begin
        if (srst)
          pk_d[g] <= MBS_RST_ZERO;
        else if (peek)
          pk_d[g] <= mrd[g];
      end
    end
  endgenerate

  // register read mux, registered one cycle after reg_rd
  logic        rd_q;
  logic        rd_side;
  logic [1:0]  rd_sel;
  logic [31:0] next_rdata;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_q    <= 1'b0;
      rd_side <= 1'b0;
      rd_sel  <= MBS_REG_CTRL;
    end
    else
    begin
      rd_q    <= reg_rd;
      rd_side <= reg_side;
      rd_sel  <= reg_sel;
    end
  end

  // read data selection per side and register
  always_comb
  begin
    next_rdata = MBS_RST_ZERO;
    unique case (rd_sel)
      MBS_REG_CTRL:
      begin
        next_rdata[MBS_CTL_EN]    = en[rd_side];
        next_rdata[MBS_CTL_PAUSE] = pause[rd_side];
        next_rdata[MBS_ST_RUN]    = run[rd_side];
        next_rdata[MBS_ST_DONE]   = done[rd_side];
        next_rdata[MBS_ST_FAIL]   = fail[rd_side];
        next_rdata[MBS_ST_PSD]    = st[rd_side] == MBS_PAUSED;
        next_rdata[MBS_CTL_SIZE +: MBS_SIZE_W] = size[rd_side];
      end
      MBS_REG_ADDR:
        next_rdata[AW-1:0] = fail_a[rd_side];
      MBS_REG_GEN:
        if (pause[rd_side] && pp_rd[rd_side])
          next_rdata = pk_d[rd_side];
        else
          next_rdata = fail_d[rd_side];
      default:
        next_rdata = MBS_RST_ZERO;
    endcase
  end

  // read data holds until the next read completes
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= MBS_RST_ZERO;
    else if (rd_q)
      reg_rdata <= next_rdata;
  end

  // instruction-side array port
  assign i_mem_en    = m_en[0];
  assign i_mem_we    = m_we[0];
  assign i_mem_addr  = m_addr[0];
  assign i_mem_wdata = m_wd[0];

  // data-side array port
  assign d_mem_en    = m_en[1];
  assign d_mem_we    = m_we[1];
  assign d_mem_addr  = m_addr[1];
  assign d_mem_wdata = m_wd[1];

  // functional enables drop while either side is enabled for test, so
  // core accesses to the arrays go out to the system bus instead
  assign i_func_en   = !(en[0] || en[1]);
  assign d_func_en   = !(en[0] || en[1]);
endmodule

// [testbench/mbs_ram_model.sv]
// array model for one side: clocked write, same-cycle read
`timescale 1ns/1ps
module mbs_ram_model #(
  parameter int AW = 12
)(
  // clock
  input  wire logic          clk,
  // array port
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [31:0]   wdata,
  output logic      [31:0]   rdata
);
  logic [31:0] mem [2**AW];
  logic [31:0] last;
  // released data line shows the inverse of its last value
  assign rdata = en ? mem[addr] : ~last;
  // write port and last-value tracking
  always @(posedge clk)
  begin
    if (en && we)
      mem[addr] <= wdata;
    last <= rdata;
  end
  // clean array at start
  initial
  begin
    last = 32'h0;
    foreach (mem[k])
      mem[k] = 32'h0;
  end
endmodule

// [testbench/mbs_selftest_properties.sv]
// port checker for the memory self-test block
`timescale 1ns/1ps
module mbs_selftest_chk
  import mbs_pkg::*;
#(
  parameter int AW = 12
)(
  // watched ports
  input wire logic          clk,
  input wire logic          srst,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic          reg_side,
  input wire logic [1:0]    reg_sel,
  input wire logic [31:0]   reg_wdata,
  input wire logic [31:0]   reg_rdata,
  input wire logic          i_mem_we,
  input wire logic [AW-1:0] i_mem_addr,
  input wire logic [31:0]   i_mem_wdata,
  input wire logic          d_mem_we,
  input wire logic [31:0]   d_mem_wdata,
  input wire logic          i_func_en,
  input wire logic          d_func_en
);
  logic [1:0]  en_h;
  logic [1:0]  ps_h;
  logic [31:0] seed_h;
  logic [31:0] base_h;
  wire         ctl_w = reg_wr && reg_sel == MBS_REG_CTRL;
  wire         ctl_r = reg_rd && reg_sel == MBS_REG_CTRL;
  // enable and pause bits as software last wrote them
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      en_h <= 2'h0;
      ps_h <= 2'h0;
    end
    else if (ctl_w)
    begin
      en_h[reg_side] <= reg_wdata[MBS_CTL_EN];
      ps_h[reg_side] <= reg_wdata[MBS_CTL_PAUSE];
    end
  end
  // instruction-side seed and start address
  always_ff @(posedge clk)
  begin
    if (reg_wr && !reg_side && !ps_h[0] && reg_sel == MBS_REG_GEN)
      seed_h <= reg_wdata;
    if (reg_wr && !reg_side && !ps_h[0] && reg_sel == MBS_REG_ADDR)
      base_h <= reg_wdata;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  func_pair_a: assert property (i_func_en == d_func_en)
    else $error("functional enables differ");
  func_track_a: assert property (i_func_en == !(|en_h))
    else $error("functional enable not tied to test enable");
  unmapped_zero_a: assert property (reg_rd && reg_sel == 2'h3
    |-> ##2 reg_rdata == 32'h0) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!$stable(reg_rdata)
    |-> $past(reg_rd, 2)) else $error("read data moved without read");
  poke_write_a: assert property (reg_wr && reg_side && ps_h[1]
    && reg_sel == MBS_REG_GEN |-> d_mem_we && d_mem_wdata == reg_wdata)
    else $error("poke not written");
  seed_write_a: assert property (ctl_w && !reg_side && en_h[0]
    && reg_wdata[MBS_CTL_START] && !reg_wdata[MBS_CTL_PAUSE] |-> ##[1:2]
    (i_mem_we && i_mem_addr == base_h[AW-1:0] && i_mem_wdata == seed_h))
    else $error("first pass write wrong");
  run_done_a: assert property (ctl_r |-> ##2
    !(reg_rdata[MBS_ST_RUN] && reg_rdata[MBS_ST_DONE]))
    else $error("running and done together");
  fail_done_a: assert property (ctl_r |-> ##2
    (!reg_rdata[MBS_ST_FAIL] || reg_rdata[MBS_ST_DONE]))
    else $error("fail without done");
endmodule
bind mbs_selftest mbs_selftest_chk #(.AW(AW)) u_chk (.clk, .srst, .reg_wr,
  .reg_rd, .reg_side, .reg_sel, .reg_wdata, .reg_rdata, .i_mem_we,
  .i_mem_addr, .i_mem_wdata, .d_mem_we, .d_mem_wdata, .i_func_en,
  .d_func_en);

// [testbench/tb_top.sv]
// testbench for the memory self-test block
`timescale 1ns/1ps
module tb_top;
  import mbs_pkg::*;
  localparam logic [31:0] SA = 32'hA5A5_5A5A;
  localparam logic [31:0] SB = 32'h1234_5678;
  localparam logic [31:0] PK = 32'hDEAD_BEEF;
  logic          clk, srst, reg_wr, reg_rd, reg_side;
  logic          i_en, i_we, d_en, d_we, i_fe, d_fe;
  logic [1:0]    reg_sel;
  logic [11:0]   i_ad, d_ad;
  logic [31:0]   reg_wdata, reg_rdata, i_wd, d_wd, i_rd, d_rd, r;
  int            fails, check_count;
  mbs_selftest u_dut (.clk(clk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_side(reg_side), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .i_mem_en(i_en),
    .i_mem_we(i_we), .i_mem_addr(i_ad), .i_mem_wdata(i_wd),
    .i_mem_rdata(i_rd), .d_mem_en(d_en), .d_mem_we(d_we),
    .d_mem_addr(d_ad), .d_mem_wdata(d_wd), .d_mem_rdata(d_rd),
    .i_func_en(i_fe), .d_func_en(d_fe));
  mbs_ram_model u_iram (.clk(clk), .en(i_en), .we(i_we), .addr(i_ad),
    .wdata(i_wd), .rdata(i_rd));
  mbs_ram_model u_dram (.clk(clk), .en(d_en), .we(d_we), .addr(d_ad),
    .wdata(d_wd), .rdata(d_rd));
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // control word: size 7 (eight words), enable/start/pause in low bits
  function automatic logic [31:0] cw(input logic [2:0] f);
    return {16'h0, 8'h07, 5'h0, f};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic s, input logic [1:0] a, input logic [31:0] v);
    reg_side = s;
    reg_sel = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic s, input logic [1:0] a);
    reg_side = s;
    reg_sel = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    repeat (2) @(posedge clk);
    #1 r = reg_rdata;
  endtask
  task automatic flg(input logic s, input logic [3:0] e);
    rd(s, MBS_REG_CTRL);
    chk({28'h0, r[7:4]}, {28'h0, e});
  endtask
  task automatic poll(input logic s, input int b);
    r = 32'h0;
    for (int n = 0; n < 100 && r[b] !== 1'b1; n++)
      rd(s, MBS_REG_CTRL);
    if (r[b] !== 1'b1)
    begin
      fails++;
      $display("unexpected at %0t: status poll timed out", $time);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #100000;
    fails++;
    finish_test;
  end
  // main sequence
  initial
  begin
    srst = 1'b1;
    {reg_wr, reg_rd, reg_side} = 3'h0;
    reg_sel = 2'h0;
    reg_wdata = 32'h0;
    fails = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    flg(0, 4'h0);
    wr(0, 2'h3, 32'hFFFF_FFFF);
    rd(0, 2'h3);
    chk(r, 32'h0);
    wr(0, MBS_REG_CTRL, cw(3'h1));
    chk({31'h0, d_fe}, 32'h0);
    wr(0, MBS_REG_ADDR, 32'h10);
    wr(0, MBS_REG_GEN, SA);
    wr(0, MBS_REG_CTRL, cw(3'h3));
    flg(0, 4'h1);
    poll(0, MBS_ST_DONE);
    flg(0, 4'h2);
    for (int k = 15; k < 25; k++)
    begin
      chk(u_iram.mem[k], (k > 15 && k < 24) ? SA : 32'h0);
      chk(u_dram.mem[k], 32'h0);
    end
    wr(1, MBS_REG_CTRL, cw(3'h1));
    wr(1, MBS_REG_ADDR, 32'h0);
    wr(1, MBS_REG_GEN, SB);
    wr(1, MBS_REG_CTRL, cw(3'h7));
    poll(1, MBS_ST_PSD);
    flg(1, 4'h8);
    chk(u_dram.mem[0], SB);
    wr(1, MBS_REG_ADDR, 32'h2);
    wr(1, MBS_REG_GEN, PK);
    rd(1, MBS_REG_GEN);
    chk(r, PK);
    wr(1, MBS_REG_CTRL, cw(3'h7));
    poll(1, MBS_ST_DONE);
    flg(1, 4'h6);
    chk(u_dram.mem[1], ~SB);
    rd(1, MBS_REG_ADDR);
    chk(r, 32'h2);
    wr(1, MBS_REG_CTRL, cw(3'h1));
    rd(1, MBS_REG_GEN);
    chk(r, PK);
    rd(1, MBS_REG_ADDR);
    chk(r, 32'h2);
    flg(1, 4'h6);
    wr(1, MBS_REG_ADDR, 32'h4);
    wr(1, MBS_REG_CTRL, cw(3'h3));
    flg(1, 4'h1);
    poll(1, MBS_ST_DONE);
    flg(1, 4'h2);
    chk(u_dram.mem[7], SB);
    chk(u_dram.mem[1], ~SB);
    wr(0, MBS_REG_CTRL, 32'h0);
    wr(1, MBS_REG_CTRL, 32'h0);
    chk({31'h0, i_fe}, 32'h1);
    finish_test;
  end
endmodule
